// ===== hdl/tcc23_pkg.sv
package tcc23_pkg;

    // =====================================================================
    // Register map (byte addresses on the word bus)
    localparam logic [7:0] MODE_CTL_OFS = 8'h1c;
    localparam logic [7:0] EN_POL_OFS = 8'h20;
    localparam logic [7:0] CH2_VAL_OFS = 8'h3c;
    localparam logic [7:0] CH3_VAL_OFS = 8'h40;
    localparam logic [7:0] STATUS_OFS = 8'h48;
    localparam logic [15:0] MODE_CTL_RST = 16'h0000;
    localparam logic [15:0] EN_POL_RST = 16'h0000;
    localparam logic [15:0] EN_POL_MASK = 16'h3f00;

    // =====================================================================
    // Per-channel byte of the mode register
    localparam int DIR_LSB = 0;
    localparam int FAST_BIT = 2;
    localparam int SHADOW_BIT = 3;
    localparam int MODE_LSB = 4;
    localparam int CLR_BIT = 7;
    localparam int DIV_LSB = 2;
    localparam int FLT_LSB = 4;
    localparam int CH3_BYTE_LSB = 8;

    // =====================================================================
    // Enable and polarity register bits
    localparam int CH2_EN_BIT = 8;
    localparam int CH2_POL_BIT = 9;
    localparam int CH2_NEN_BIT = 10;
    localparam int CH2_NPOL_BIT = 11;
    localparam int CH3_EN_BIT = 12;
    localparam int CH3_POL_BIT = 13;

    // =====================================================================
    // Field codes
    localparam logic [1:0] DIR_OUT = 2'h0;
    localparam logic [1:0] DIR_OWN = 2'h1;
    localparam logic [1:0] DIR_OTHER = 2'h2;
    localparam logic [1:0] DIR_TRIG = 2'h3;
    localparam logic [1:0] LOCK_FULL = 2'h3;

    typedef enum logic [2:0] {
        TCC23_TIMING,
        TCC23_SET,
        TCC23_CLEAR,
        TCC23_TOGGLE,
        TCC23_FORCE_LO,
        TCC23_FORCE_HI,
        TCC23_PWM0,
        TCC23_PWM1
    } tcc23_mode_t;

    // =====================================================================
    // Trigger latency to the output reference, and counter widths
    localparam int TRIG_LAT_SLOW = 5;
    localparam int TRIG_LAT_FAST = 3;
    localparam int TRIG_PIPE_W = 3;
    localparam int FLT_CNT_W = 4;
    localparam int DIV_CNT_W = 5;

endpackage

// ===== hdl/tcc23_ctl.sv
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module tcc23_ctl (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] timer_count_value_i,
    input wire logic count_down_i,
    input wire logic update_event_i,
    input wire logic [1:0] lock_level_i,
    input wire logic dead_time_sample_clk_i,
    input wire logic timer_kernel_clk_i,
    input wire logic ext_trigger_filtered_i,
    input wire logic internal_trigger_sig_i,
    input wire logic trigger_edge_i,
    input wire logic chan2_input_i,
    input wire logic chan3_input_i,
    output logic chan2_out_pin_o,
    output logic chan2_out_comp_pin_o,
    output logic chan3_out_pin_o,
    output logic chan2_capture_o,
    output logic chan3_capture_o
);

    // =====================================================================
    // Helper functions

    // Filter length N and dead-time divider exponent for a filter code
    function automatic logic [3:0] flt_len(input logic [3:0] code);
        logic [3:0] n;
        n = 4'h1;
        case (code)
            4'h0: n = 4'h1;
            4'h1: n = 4'h2;
            4'h2: n = 4'h4;
            4'ha, 4'hd: n = 4'h5;
            4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    function automatic logic [2:0] flt_div(input logic [3:0] code);
        logic [2:0] d;
        d = 3'h0;
        case (code)
            4'h4, 4'h5: d = 3'h1;
            4'h6, 4'h7: d = 3'h2;
            4'h8, 4'h9: d = 3'h3;
            4'ha, 4'hb, 4'hc: d = 3'h4;
            4'hd, 4'he, 4'hf: d = 3'h5;
            default: d = 3'h0;
        endcase
        return d;
    endfunction

    // Capture prescaler: number of edges minus one
    function automatic logic [2:0] div_lim(input logic [1:0] code);
        return 3'((4'h1 << code) - 4'h1);
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // =====================================================================
    // Registers
    logic [15:0] mode_q;
    logic [15:0] enpol_q;
    logic [15:0] cmp_shadow_q [2];
    logic [15:0] cmp_active_q [2];
    logic [15:0] capt_q [2];
    logic [31:0] rdata_q;
    logic ack_q;
    logic wait_q;
    logic [1:0] cmp_ref_q;

    // =====================================================================
    // Bus decode (one wait cycle on every access)
    wire logic req = (avs_read_i | avs_write_i) & ~ack_q;
    // Writes land on the edge at which waitrequest is seen low
    wire logic wr_en = avs_write_i & ack_q;
    wire logic hit_mode = avs_address_i == tcc23_pkg::MODE_CTL_OFS;
    wire logic hit_enpol = avs_address_i == tcc23_pkg::EN_POL_OFS;
    wire logic hit_v2 = avs_address_i == tcc23_pkg::CH2_VAL_OFS;
    wire logic hit_v3 = avs_address_i == tcc23_pkg::CH3_VAL_OFS;
    wire logic hit_stat = avs_address_i == tcc23_pkg::STATUS_OFS;
    wire logic [15:0] mode_wr = lane16(mode_q, avs_writedata_i, avs_byteenable_i);
    wire logic [15:0] enpol_wr = lane16(enpol_q, avs_writedata_i, avs_byteenable_i);

    // Per-channel views
    wire logic [1:0] chen = {enpol_q[tcc23_pkg::CH3_EN_BIT], enpol_q[tcc23_pkg::CH2_EN_BIT]};
    wire logic [1:0] chpol = {enpol_q[tcc23_pkg::CH3_POL_BIT], enpol_q[tcc23_pkg::CH2_POL_BIT]};
    wire logic [7:0] cbyte [2];
    assign cbyte[0] = mode_q[7:0];
    assign cbyte[1] = mode_q[15:8];

    // Field merge honouring the direction guard and the lock
    logic [15:0] mode_d;
    always_comb
    begin
        mode_d = mode_wr;
        for (int c = 0; c < 2; c++)
        begin
            if (chen[c])
            begin
                mode_d[8*c +: 2] = mode_q[8*c +: 2];
            end
            if (lock_level_i == tcc23_pkg::LOCK_FULL && mode_q[8*c +: 2] == tcc23_pkg::DIR_OUT)
            begin
                mode_d[8*c+4 +: 3] = mode_q[8*c+4 +: 3];
                mode_d[8*c+3] = mode_q[8*c+3];
            end
        end
    end

    // Control registers
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mode_q <= tcc23_pkg::MODE_CTL_RST;
            enpol_q <= tcc23_pkg::EN_POL_RST;
            ack_q <= 1'b0;
            wait_q <= 1'b1;
        end
        else
        begin
            ack_q <= req;
            wait_q <= ~req;
            if (wr_en && hit_mode)
            begin
                mode_q <= mode_d;
            end
            if (wr_en && hit_enpol)
            begin
                enpol_q <= enpol_wr & tcc23_pkg::EN_POL_MASK;
            end
        end
    end

    // Read mux
    wire logic [15:0] stat_word = {10'h000, cmp_ref_q, chen, 2'h0};
    wire logic [15:0] rd_mux = hit_mode ? mode_q :
                               hit_enpol ? enpol_q :
                               hit_v2 ? (mode_q[1:0] == tcc23_pkg::DIR_OUT ? cmp_shadow_q[0] : capt_q[0]) :
                               hit_v3 ? (mode_q[9:8] == tcc23_pkg::DIR_OUT ? cmp_shadow_q[1] : capt_q[1]) :
                               hit_stat ? stat_word : 16'h0000;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (req && avs_read_i)
        begin
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // =====================================================================
    // Trigger pipeline for the slow and fast paths
    localparam int TRIG_DEPTH = tcc23_pkg::TRIG_LAT_SLOW - 1;
    logic [TRIG_DEPTH-1:0] trig_pipe_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            trig_pipe_q <= '0;
        end
        else
        begin
            trig_pipe_q <= {trig_pipe_q[TRIG_DEPTH-2:0], trigger_edge_i};
        end
    end
    // Reference registers at stage 4 with output register makes 5; fast path taps stage 2
    wire logic trig_slow = trig_pipe_q[tcc23_pkg::TRIG_LAT_SLOW-2];
    wire logic trig_fast = trig_pipe_q[tcc23_pkg::TRIG_LAT_FAST-2];

    // Dead-time sample divider shared by both filters
    logic [tcc23_pkg::DIV_CNT_W-1:0] dts_cnt_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            dts_cnt_q <= '0;
        end
        else if (dead_time_sample_clk_i)
        begin
            dts_cnt_q <= dts_cnt_q + 5'h01;
        end
    end

    // =====================================================================
    // Per-channel logic
    logic [1:0] pwm_prev_q;
    logic [1:0] flt_q;
    logic [1:0] flt_prev_q;
    logic [tcc23_pkg::FLT_CNT_W-1:0] flt_cnt_q [2];
    logic [2:0] edge_cnt_q [2];
    logic [1:0] capt_q_pulse;
    wire logic [1:0] pin_raw = {chan3_input_i, chan2_input_i};

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        wire logic [7:0] b = cbyte[c];
        wire logic [1:0] dir = b[1:0];
        wire tcc23_pkg::tcc23_mode_t md = tcc23_pkg::tcc23_mode_t'(b[6:4]);
        wire logic is_pwm = md == tcc23_pkg::TCC23_PWM0 || md == tcc23_pkg::TCC23_PWM1;
        wire logic match = timer_count_value_i == cmp_active_q[c];
        wire logic below = timer_count_value_i < cmp_active_q[c];
        wire logic above = timer_count_value_i > cmp_active_q[c];
        // PWM0 active level; PWM1 is its inverse
        wire logic pwm0 = count_down_i ? ~above : below;
        wire logic pwm_lvl = (md == tcc23_pkg::TCC23_PWM0) ? pwm0 : ~pwm0;
        wire logic ftrig = is_pwm && (b[tcc23_pkg::FAST_BIT] ? trig_fast : trig_slow);
        wire logic pwm_chg = pwm_lvl != pwm_prev_q[c] || !is_pwm;

        // Filter sampling: kernel clock for codes 1 to 3, otherwise dead-time clock divided per code (undivided for code 0)
        wire logic [3:0] fcode = b[7:4];
        wire logic [2:0] fdiv = flt_div(fcode);
        wire logic [4:0] dmask = 5'((6'h01 << fdiv) - 6'h01);
        wire logic samp = (fcode == 4'h0) ? dead_time_sample_clk_i :
                          (fcode <= 4'h3) ? timer_kernel_clk_i :
                          dead_time_sample_clk_i && ((dts_cnt_q & dmask) == dmask);
        wire logic in_pin = (dir == tcc23_pkg::DIR_OWN) ? flt_q[c] :
                            (dir == tcc23_pkg::DIR_OTHER) ? flt_q[1-c] :
                            (dir == tcc23_pkg::DIR_TRIG) ? internal_trigger_sig_i : 1'b0;
        wire logic sel_in = in_pin ^ chpol[c];
        wire logic sel_prev = flt_prev_q[c];
        wire logic qual = chen[c] && dir != tcc23_pkg::DIR_OUT && sel_in && !sel_prev;

        // Output reference generation
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i)
            begin
                cmp_ref_q[c] <= 1'b0;
                pwm_prev_q[c] <= 1'b0;
            end
            else
            begin
                pwm_prev_q[c] <= pwm_lvl;
                if (b[tcc23_pkg::CLR_BIT] && ext_trigger_filtered_i)
                    cmp_ref_q[c] <= 1'b0;
                else if (ftrig)
                    cmp_ref_q[c] <= md == tcc23_pkg::TCC23_PWM0;
                else
                begin
                    case (md)
                        tcc23_pkg::TCC23_TIMING: cmp_ref_q[c] <= cmp_ref_q[c];
                        tcc23_pkg::TCC23_SET: if (match) cmp_ref_q[c] <= 1'b1;
                        tcc23_pkg::TCC23_CLEAR: if (match) cmp_ref_q[c] <= 1'b0;
                        tcc23_pkg::TCC23_TOGGLE: if (match) cmp_ref_q[c] <= ~cmp_ref_q[c];
                        tcc23_pkg::TCC23_FORCE_LO: cmp_ref_q[c] <= 1'b0;
                        tcc23_pkg::TCC23_FORCE_HI: cmp_ref_q[c] <= 1'b1;
                        default: if (pwm_chg) cmp_ref_q[c] <= pwm_lvl;
                    endcase
                end
            end
        end

        // Compare value shadow and active copy
        wire logic wr_val = wr_en && (c == 0 ? hit_v2 : hit_v3) && dir == tcc23_pkg::DIR_OUT;
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i)
            begin
                cmp_shadow_q[c] <= 16'h0000;
                cmp_active_q[c] <= 16'h0000;
            end
            else
            begin
                if (wr_val)
                    cmp_shadow_q[c] <= lane16(cmp_shadow_q[c], avs_writedata_i, avs_byteenable_i);
                if (!b[tcc23_pkg::SHADOW_BIT] && wr_val)
                    cmp_active_q[c] <= lane16(cmp_shadow_q[c], avs_writedata_i, avs_byteenable_i);
                else if (b[tcc23_pkg::SHADOW_BIT] && update_event_i)
                    cmp_active_q[c] <= cmp_shadow_q[c];
            end
        end

        // Digital input filter: N agreeing samples before the output moves
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i)
            begin
                flt_q[c] <= 1'b0;
                flt_cnt_q[c] <= 4'h0;
                flt_prev_q[c] <= 1'b0;
            end
            else
            begin
                flt_prev_q[c] <= sel_in;
                if (samp)
                begin
                    if (pin_raw[c] == flt_q[c])
                        flt_cnt_q[c] <= 4'h0;
                    else if (flt_cnt_q[c] + 4'h1 >= flt_len(fcode))
                    begin
                        flt_q[c] <= pin_raw[c];
                        flt_cnt_q[c] <= 4'h0;
                    end
                    else
                        flt_cnt_q[c] <= flt_cnt_q[c] + 4'h1;
                end
            end
        end

        // Capture prescaler and counter capture
        always_ff @(posedge clk_sys_i)
        begin
            if (sys_rst_i)
            begin
                edge_cnt_q[c] <= 3'h0;
                capt_q_pulse[c] <= 1'b0;
                capt_q[c] <= 16'h0000;
            end
            else
            begin
                capt_q_pulse[c] <= 1'b0;
                if (!chen[c])
                    edge_cnt_q[c] <= 3'h0;
                else if (qual)
                begin
                    if (edge_cnt_q[c] == div_lim(b[tcc23_pkg::DIV_LSB +: 2]))
                    begin
                        edge_cnt_q[c] <= 3'h0;
                        capt_q_pulse[c] <= 1'b1;
                        capt_q[c] <= timer_count_value_i;
                    end
                    else
                        edge_cnt_q[c] <= edge_cnt_q[c] + 3'h1;
                end
            end
        end
    end

    // =====================================================================
    // Pin drivers: polarity and enable applied, registered
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            chan2_out_pin_o <= 1'b0;
            chan2_out_comp_pin_o <= 1'b0;
            chan3_out_pin_o <= 1'b0;
        end
        else
        begin
            chan2_out_pin_o <= chen[0] && mode_q[1:0] == tcc23_pkg::DIR_OUT &&
                               (cmp_ref_q[0] ^ chpol[0]);
            chan2_out_comp_pin_o <= enpol_q[tcc23_pkg::CH2_NEN_BIT] &&
                                    mode_q[1:0] == tcc23_pkg::DIR_OUT &&
                                    (~cmp_ref_q[0] ^ enpol_q[tcc23_pkg::CH2_NPOL_BIT]);
            chan3_out_pin_o <= chen[1] && mode_q[9:8] == tcc23_pkg::DIR_OUT &&
                               (cmp_ref_q[1] ^ chpol[1]);
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign chan2_capture_o = capt_q_pulse[0];
    assign chan3_capture_o = capt_q_pulse[1];

    // =====================================================================
    // Checks
    chk_dir_guard: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        chen[0] |=> $stable(mode_q[1:0]) || $past(!chen[0]))
        else $error("direction changed while enabled");
    chk_force_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (g_ch[0].md == tcc23_pkg::TCC23_FORCE_LO && !g_ch[0].ftrig) |=> !cmp_ref_q[0])
        else $error("force low not held");
    chk_ref_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mode_q[tcc23_pkg::CLR_BIT] && ext_trigger_filtered_i) |=> !cmp_ref_q[0])
        else $error("reference not cleared by trigger");
    chk_presc_rst: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !chen[0] |=> edge_cnt_q[0] == 3'h0)
        else $error("prescaler not reset");
    chk_timing_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (g_ch[1].md == tcc23_pkg::TCC23_TIMING && !mode_q[15]) |=> $stable(cmp_ref_q[1]))
        else $error("timing mode changed reference");
    chk_shadow_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (mode_q[tcc23_pkg::SHADOW_BIT] && update_event_i && !(wr_en && hit_v2))
        |=> cmp_active_q[0] == $past(cmp_shadow_q[0]))
        else $error("shadow not loaded on update");
    chk_enpol_top: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        enpol_q[15:14] == 2'h0)
        else $error("reserved enable bits set");
    chk_bus_answer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (req && !ack_q) |=> !avs_waitrequest_o)
        else $error("bus not answered in one cycle");

endmodule

// ===== verification/tcc23_ctl_bench.sv
`timescale 1ns/10ps
module tcc23_ctl_bench;
    // ====================
    // Stimulus, outputs and counters
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h3;
    logic [31:0] rdat;
    logic wait_rq;
    logic [15:0] cnt = 16'h0000;
    logic dn = 1'b0;
    logic upd = 1'b0;
    logic [1:0] lock = 2'h0;
    logic ext = 1'b0;
    logic trig = 1'b0;
    logic in2 = 1'b0;
    logic p2, p2n, p3, cap2, cap3, seen;
    logic [31:0] rdv;
    int err_count = 0;
    int checks = 0;
    int cap_n = 0;
    int cap3_n = 0;

    // ====================
    // Design under test, sample clocks held on for full-rate filtering
    tcc23_ctl i_tcc23_ctl (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_rq),
        .timer_count_value_i(cnt), .count_down_i(dn), .update_event_i(upd),
        .lock_level_i(lock), .dead_time_sample_clk_i(1'b1), .timer_kernel_clk_i(1'b1),
        .ext_trigger_filtered_i(ext), .internal_trigger_sig_i(1'b0), // no source, no code 11
        .trigger_edge_i(trig), .chan2_input_i(in2), .chan3_input_i(1'b0),
        .chan2_out_pin_o(p2), .chan2_out_comp_pin_o(p2n), .chan3_out_pin_o(p3),
        .chan2_capture_o(cap2), .chan3_capture_o(cap3)
    );

    // Clock of 40 ns period
    always #20 clk_sys_i = ~clk_sys_i;

    // Count capture pulses from both channels
    always @(posedge clk_sys_i)
    begin
        if (cap2 === 1'b1)
            cap_n <= cap_n + 1;
        if (cap3 === 1'b1)
            cap3_n <= cap3_n + 1;
    end

    // ====================
    // Tasks
    task automatic stop_test();
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Bus access held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n = 0;
        @(posedge clk_sys_i);
        adr <= a;
        wr_s <= w;
        rd_s <= !w;
        wd <= d;
        be <= b;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (wait_rq !== 1'b0 && n < 20);
        rdv = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'h3);
        chk(rdv, e);
    endtask

    task automatic wm(input logic [15:0] d);
        acc(1'b1, tcc23_pkg::MODE_CTL_OFS, {16'h0, d}, 4'h3);
    endtask

    task automatic we(input logic [15:0] d);
        acc(1'b1, tcc23_pkg::EN_POL_OFS, {16'h0, d}, 4'h3);
    endtask

    task automatic pin(input logic e);
        tick(4);
        chk({31'h0, p2}, {31'h0, e});
    endtask

    task automatic pulse_in(input int hi);
        @(posedge clk_sys_i);
        in2 <= 1'b1;
        tick(hi);
        in2 <= 1'b0;
        tick(12);
    endtask

    // ====================
    // Main sequence
    initial
    begin
        tick(16);
        sys_rst_i <= 1'b0;
        rd(tcc23_pkg::EN_POL_OFS, 32'h0);
        rd(8'h04, 32'h0);
        acc(1'b1, tcc23_pkg::EN_POL_OFS, 32'h3f00, 4'hf);
        rd(tcc23_pkg::EN_POL_OFS, 32'h3f00);
        we(16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            wm(i[0] ? 16'h0050 : 16'h0040);
            we({6'h00, i[1], 9'h100});
            pin(i[0] ^ i[1]);
        end
        we(16'h0500);
        wm(16'h0040);
        tick(4);
        chk({31'h0, p2n}, 32'h1);
        wm(16'h0050);
        tick(4);
        chk({31'h0, p2n}, 32'h0);
        we(16'h0100);
        wm(16'h0051);
        rd(tcc23_pkg::MODE_CTL_OFS, 32'h0050);
        we(16'h0100);
        lock <= 2'h3;
        wm(16'h0041);
        rd(tcc23_pkg::MODE_CTL_OFS, 32'h0050);
        lock <= 2'h0;
        wm(16'h00d0);
        ext <= 1'b1;
        pin(1'b0);
        ext <= 1'b0;
        pin(1'b1);
        acc(1'b1, tcc23_pkg::CH2_VAL_OFS, 32'h40, 4'h3);
        wm(16'h0040);
        wm(16'h0010);
        pin(1'b0);
        cnt <= 16'h0040;
        pin(1'b1);
        wm(16'h0020);
        pin(1'b0);
        cnt <= 16'h0000;
        wm(16'h0030);
        cnt <= 16'h0040;
        tick(1);
        cnt <= 16'h0000;
        pin(1'b1);
        wm(16'h0000);
        cnt <= 16'h0040;
        pin(1'b1);
        for (int j = 0; j < 8; j++)
        begin
            cnt <= j[0] ? 16'h0050 : 16'h0010;
            dn <= j[1];
            wm(j[2] ? 16'h0070 : 16'h0060);
            pin(~(j[0] ^ j[2]));
        end
        dn <= 1'b0;
        cnt <= 16'h0030;
        wm(16'h0068);
        pin(1'b1);
        acc(1'b1, tcc23_pkg::CH2_VAL_OFS, 32'h20, 4'h3);
        pin(1'b1);
        upd <= 1'b1;
        tick(1);
        upd <= 1'b0;
        pin(1'b0);
        wm(16'h0064);
        acc(1'b1, tcc23_pkg::CH2_VAL_OFS, 32'h40, 4'h3);
        cnt <= 16'h0050;
        pin(1'b0);
        trig <= 1'b1;
        tick(1);
        trig <= 1'b0;
        seen = 1'b0;
        repeat (4)
        begin
            tick(1);
            seen = seen | p2;
        end
        chk({31'h0, seen}, 32'h1);
        we(16'h1000);
        wm(16'h5000);
        tick(4);
        chk({31'h0, p3}, 32'h1);
        wm(16'h4000);
        tick(4);
        chk({31'h0, p3}, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            we(16'h0000);
            wm({12'h000, k[1:0], 2'h1});
            we(16'h0100);
            cap_n <= 0;
            repeat (8) pulse_in(3);
            chk(cap_n, 32'h8 >> k);
        end
        cap_n <= 0;
        repeat (4) pulse_in(3);
        we(16'h0000);
        we(16'h0100);
        repeat (4) pulse_in(3);
        chk(cap_n, 32'h0);
        we(16'h0000);
        wm(16'h0031);
        we(16'h0100);
        cap_n <= 0;
        pulse_in(3);
        chk(cap_n, 32'h0);
        pulse_in(14);
        chk(cap_n, 32'h1);
        we(16'h0000);
        wm(16'h0200);
        we(16'h1000);
        pulse_in(3);
        chk(cap3_n, 32'h1);
        stop_test();
    end
endmodule
